// ==== fault_supervisor_cfg.svh ====
`ifndef FAULT_SUPERVISOR_CFG_SVH
`define FAULT_SUPERVISOR_CFG_SVH

// Clock rate in Hz
`define CLK_HZ           200000000
// Times in their own units
`define PH_LOSS_1PH_MS   500
`define PH_LOSS_3PH_MS   200
`define CTRL_LOSS_MS     200
`define LOCKED_ROTOR_MS  200
`define RESTART_GAP_S    60
// Derived cycle counts (least times round up, +1 makes "for more than" strict)
`define PH_LOSS_1PH_CYC  ((`CLK_HZ / 1000) * `PH_LOSS_1PH_MS)
`define PH_LOSS_3PH_CYC  ((`CLK_HZ / 1000) * `PH_LOSS_3PH_MS)
`define CTRL_LOSS_CYC    ((`CLK_HZ / 1000) * `CTRL_LOSS_MS + 1)
`define LOCKED_ROTOR_CYC ((`CLK_HZ / 1000) * `LOCKED_ROTOR_MS + 1)
// Gap product needs 34 bits; a plain 32-bit product would wrap
`define RESTART_GAP_CYC  (36'(`CLK_HZ) * `RESTART_GAP_S)
// Restart attempts before escalating
`define MAX_ATTEMPTS     6
// History depth
`define HIST_DEPTH       5
// Locked rotor multiple of rated current
`define LR_MULT          5
// Fault codes
`define FC_NONE          4'h0
`define FC_PHASE_LOSS    4'h1
`define FC_LINE_FREQ     4'h2
`define FC_SUPPLY        4'h3
`define FC_CTRL_LINE     4'h4
`define FC_LOCKED_ROTOR  4'h5
`define FC_THERMISTOR    4'h6
`define FC_EXTERNAL      4'h7
`define FC_UNDERLOAD     4'h8
`define FC_ESCALATED     4'h9

`endif

// ==== fault_supervisor_pkg.sv ====
package fault_supervisor_pkg;

   typedef enum logic [1:0] {
      st_run,
      st_auto_wait,
      st_manual,
      st_armed
   } sup_state_t;

   // Current-sensing inputs grouped together
   typedef struct packed {
      logic [15:0] phase_a;
      logic [15:0] phase_b;
      logic [15:0] phase_c;
      logic [15:0] rated;
      logic [15:0] phase_loss_current_threshold;
   } current_meas_t;

   // Relay and display outputs
   typedef struct packed {
      logic       run_status_relay;
      logic       isolation_or_fault_relay;
      logic       display_flash;
      logic [3:0] display_code;
   } indicate_t;

endpackage : fault_supervisor_pkg

// ==== motor_starter_fault_supervisor.sv ====
// Functional notes
// - Auto-reset fault locks the starter and freewheels the motor.
// - Auto-reset fault restarts the motor once the condition disappears.
// - Auto-reset fault opens the run-status relay.
// - Auto-reset fault opens configurable relay only in isolation mode.
// - Fault code flashes exactly while the fault condition persists.
// - Five most recent faults kept, readable from outside.
// - Up to six restart attempts spaced 60 s while fault persists.
// - Fault still present at sixth attempt trips to manual-reset state.
// - On that trip the configurable relay opens in fault-relay mode.
// - Phase loss: current below threshold 0.5 s single, 0.2 s three-phase.
// - Line frequency out of configured tolerance is an auto-reset fault.
// - Control supply lost over 200 ms is a control-line failure.
// - Supply found faulty at a run command is an auto-reset fault.
// - Without automatic restart, auto-reset faults act as manual-reset faults.
// - Manual-reset fault locks, freewheels, opens both relays.
// - Fault-clear input assigned: run edges do not clear a fault.
// - Locked rotor only bypassed steady state, current >= 5x rated over 0.2 s.
// - Thermistor over-temperature is a manual-reset fault.
`timescale 1ns/100ps
`include "fault_supervisor_cfg.svh"

module motor_starter_fault_supervisor (
   input  wire logic                                 sys_clk,
   input  wire logic                                 rstn,
   input  wire logic                                 run_cmd,
   input  wire logic                                 assignable_logic_input,
   input  wire logic                                 fault_clear_input_function,
   input  wire logic                                 auto_restart_en,
   input  wire logic                                 relay1_is_isolation,
   input  wire logic                                 single_phase,
   input  wire fault_supervisor_pkg::current_meas_t  meas,
   input  wire logic                                 freq_out_of_band,
   input  wire logic                                 control_supply_ok,
   input  wire logic                                 power_supply_ok,
   input  wire logic                                 bypass_steady,
   input  wire logic                                 thermistor_hot,
   input  wire logic                                 external_fault,
   input  wire logic                                 motor_underload_fault,
   input  wire logic [2:0]                           hist_sel,
   output fault_supervisor_pkg::indicate_t           ind_ff,
   output logic                                      motor_drive_en_ff,
   output logic [3:0]                                hist_code_ff,
   output logic [2:0]                                attempts_ff
);
   import fault_supervisor_pkg::*;

   localparam logic [31:0] PLOSS1_CYC = 32'(`PH_LOSS_1PH_CYC);
   localparam logic [31:0] PLOSS3_CYC = 32'(`PH_LOSS_3PH_CYC);
   localparam logic [31:0] CLL_CYC    = 32'(`CTRL_LOSS_CYC);
   localparam logic [31:0] LR_CYC     = 32'(`LOCKED_ROTOR_CYC);
   localparam logic [35:0] GAP_DEF    = 36'(`RESTART_GAP_CYC);

   // Long gap is a parameter so simulation can shorten the 60 s wait
   parameter logic [35:0] RESTART_GAP_CYC = GAP_DEF;

   // True when a phase draws at least the locked-rotor multiple of rated
   function automatic logic over_lr(input logic [15:0] ph, input logic [15:0] rated);
      over_lr = {3'h0, ph} >= (19'(`LR_MULT) * {3'h0, rated}); // 19 bits hold five times full scale
   endfunction : over_lr

   // Qualifier timers: 0 phase loss, 1 control line, 2 locked rotor
   logic [2:0]  qcond;
   logic [2:0]  qhit;
   logic [31:0] qlim [3];

   // Raw condition for each qualified fault
   always_comb begin
      qcond[0] = motor_drive_en_ff &&
                 (meas.phase_a < meas.phase_loss_current_threshold ||
                  meas.phase_b < meas.phase_loss_current_threshold ||
                  meas.phase_c < meas.phase_loss_current_threshold);
      qcond[1] = !control_supply_ok;
      qcond[2] = bypass_steady && (over_lr(meas.phase_a, meas.rated) ||
                 over_lr(meas.phase_b, meas.rated) || over_lr(meas.phase_c, meas.rated));
      qlim[0]  = single_phase ? PLOSS1_CYC : PLOSS3_CYC;
      qlim[1]  = CLL_CYC;
      qlim[2]  = LR_CYC;
   end

   // Each timer counts while its condition holds and saturates at its limit
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_qual
         logic [31:0] cnt_ff;  // Local per timer, so one process owns each register
         logic [31:0] nxt_cnt;
         always_comb begin
            if (!qcond[gi])
               nxt_cnt = 32'h0;
            else if (cnt_ff < qlim[gi])
               nxt_cnt = cnt_ff + 32'h1;
            else
               nxt_cnt = cnt_ff;
         end
         assign qhit[gi] = qcond[gi] && (cnt_ff >= qlim[gi]);
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn)
               cnt_ff <= 32'h0;
            else
               cnt_ff <= nxt_cnt;
         end
      end
   endgenerate

   // Run edge detect; supply check latched on a run edge
   logic run_d_ff;
   logic supply_bad_ff;
   logic nxt_supply_bad;
   logic run_rise;
   assign run_rise = run_cmd && !run_d_ff;

   always_comb begin
      nxt_supply_bad = supply_bad_ff;
      if (run_rise && !power_supply_ok)
         nxt_supply_bad = 1'b1;
      else if (power_supply_ok)
         nxt_supply_bad = 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         run_d_ff      <= 1'b0;
         supply_bad_ff <= 1'b0;
      end else begin
         run_d_ff      <= run_cmd;
         supply_bad_ff <= nxt_supply_bad;
      end
   end

   // Fault classification with fixed priority, manual class first
   logic       auto_flt;
   logic       man_flt;
   logic [3:0] auto_code;
   logic [3:0] man_code;

   always_comb begin
      man_flt  = thermistor_hot || external_fault || motor_underload_fault || qhit[2];
      man_code = thermistor_hot ? `FC_THERMISTOR :
                 qhit[2]        ? `FC_LOCKED_ROTOR :
                 external_fault ? `FC_EXTERNAL : `FC_UNDERLOAD;
      auto_flt  = qhit[0] || freq_out_of_band || supply_bad_ff || qhit[1];
      auto_code = qhit[1]          ? `FC_CTRL_LINE :
                  qhit[0]          ? `FC_PHASE_LOSS :
                  freq_out_of_band ? `FC_LINE_FREQ : `FC_SUPPLY;
   end

   // Supervisor state, attempt counter and restart interval
   sup_state_t  state_ff;
   sup_state_t  nxt_state;
   logic [2:0]  nxt_attempts;
   logic [35:0] gap_ff;
   logic [35:0] nxt_gap;
   logic [3:0]  latched_ff;
   logic [3:0]  nxt_latched;
   logic        escalated_ff;
   logic        nxt_escalated;
   logic        clear_ok;
   logic        log_evt;
   logic [3:0]  log_code;

   // run edge only clears when no logic input owns reset
   assign clear_ok = fault_clear_input_function ? assignable_logic_input : run_rise;

   always_comb begin
      nxt_state     = state_ff;
      nxt_attempts  = attempts_ff;
      nxt_gap       = gap_ff;
      nxt_latched   = latched_ff;
      nxt_escalated = escalated_ff;
      log_evt       = 1'b0;
      log_code      = `FC_NONE;
      unique case (state_ff)
         st_run: begin
            if (man_flt || (auto_flt && !auto_restart_en)) begin
               nxt_state   = st_manual;
               nxt_latched = man_flt ? man_code : auto_code;
               log_evt     = 1'b1;
               log_code    = nxt_latched;
            end else if (auto_flt) begin
               nxt_state   = st_auto_wait;
               nxt_latched = auto_code;
               nxt_gap     = 36'h0;
               log_evt     = 1'b1;
               log_code    = auto_code;
            end else begin
               nxt_attempts = 3'h0;
            end
         end
         st_auto_wait: begin
            if (man_flt) begin
               nxt_state   = st_manual;
               nxt_latched = man_code;
               log_evt     = 1'b1;
               log_code    = man_code;
            end else if (!auto_flt) begin
               nxt_state = st_run;
            end else if (gap_ff >= RESTART_GAP_CYC - 36'h1) begin
               nxt_gap      = 36'h0;
               nxt_attempts = attempts_ff + 3'h1;
               if (attempts_ff + 3'h1 >= 3'(`MAX_ATTEMPTS)) begin
                  nxt_state     = st_manual;
                  nxt_escalated = 1'b1;
                  log_evt       = 1'b1;
                  log_code      = `FC_ESCALATED;
               end
            end else begin
               nxt_gap = gap_ff + 36'h1;
            end
         end
         st_manual: begin
            if (!man_flt && !auto_flt && clear_ok) begin
               nxt_state     = st_armed;
               nxt_attempts  = 3'h0;
               nxt_gap       = 36'h0;
               nxt_escalated = 1'b0;
               nxt_latched   = `FC_NONE;
            end
         end
         st_armed: begin
            if (man_flt || auto_flt) begin
               nxt_state   = st_manual;
               nxt_latched = man_flt ? man_code : auto_code;
               log_evt     = 1'b1;
               log_code    = nxt_latched;
            end else if (run_rise) begin
               nxt_state = st_run;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff     <= st_run;
         attempts_ff  <= 3'h0;
         gap_ff       <= 36'h0;
         latched_ff   <= `FC_NONE;
         escalated_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         attempts_ff  <= nxt_attempts;
         gap_ff       <= nxt_gap;
         latched_ff   <= nxt_latched;
         escalated_ff <= nxt_escalated;
      end
   end

   // Five-entry history, newest in slot 0
   logic [3:0] hist_ff [`HIST_DEPTH];
   logic [3:0] nxt_hist [`HIST_DEPTH];

   always_comb begin
      for (int i = 0; i < `HIST_DEPTH; i++)
         nxt_hist[i] = hist_ff[i];
      if (log_evt) begin
         nxt_hist[0] = log_code;
         for (int i = 1; i < `HIST_DEPTH; i++)
            nxt_hist[i] = hist_ff[i-1];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `HIST_DEPTH; i++)
            hist_ff[i] <= `FC_NONE;
      end else begin
         for (int i = 0; i < `HIST_DEPTH; i++)
            hist_ff[i] <= nxt_hist[i];
      end
   end

   // Output decode; registered so relays never see decode glitches
   indicate_t  nxt_ind;
   logic       nxt_drive;
   logic [3:0] nxt_hcode;
   logic       fault_live;

   always_comb begin
      fault_live            = (state_ff == st_auto_wait) ? auto_flt :
                              (state_ff == st_manual) ? (man_flt || auto_flt) : 1'b0;
      nxt_ind.display_flash = fault_live;
      nxt_ind.display_code  = fault_live ? (man_flt ? man_code : auto_code) : `FC_NONE;
      nxt_drive             = (state_ff == st_run) && run_cmd && !man_flt && !auto_flt;
      // run-status relay opens on any fault
      nxt_ind.run_status_relay = (state_ff == st_run) && !man_flt && !auto_flt;
      if (state_ff == st_auto_wait)
         // isolation opens, fault relay stays closed
         nxt_ind.isolation_or_fault_relay = !relay1_is_isolation;
      else if (state_ff == st_manual)
         // manual and escalated trips open it
         nxt_ind.isolation_or_fault_relay = 1'b0;
      else
         nxt_ind.isolation_or_fault_relay = 1'b1;
      nxt_hcode = (hist_sel < 3'(`HIST_DEPTH)) ? hist_ff[hist_sel] : `FC_NONE;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ind_ff            <= '0;
         motor_drive_en_ff <= 1'b0;
         hist_code_ff      <= `FC_NONE;
      end else begin
         ind_ff            <= nxt_ind;
         motor_drive_en_ff <= nxt_drive;
         hist_code_ff      <= nxt_hcode;
      end
   end

   // Assertions
   a_manual_relays_open: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == st_manual |=> !ind_ff.run_status_relay && !ind_ff.isolation_or_fault_relay)
      else $error("manual fault left a relay closed");
   a_auto_relay_mode: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == st_auto_wait |=> ind_ff.isolation_or_fault_relay == !$past(relay1_is_isolation))
      else $error("configurable relay wrong in auto fault");
   a_auto_no_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff != st_run |=> !motor_drive_en_ff)
      else $error("motor driven while locked");
   a_auto_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == st_auto_wait && !auto_flt && !man_flt |=> state_ff == st_run)
      else $error("no restart after fault cleared");
   a_escalate_six: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(escalated_ff) |-> attempts_ff == 3'(`MAX_ATTEMPTS) && state_ff == st_manual)
      else $error("escalation not at sixth attempt");
   a_attempt_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == st_run && !auto_flt && !man_flt |=> attempts_ff == 3'h0)
      else $error("attempts not reset after restart");
   a_run_edge_blocked: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == st_manual && fault_clear_input_function && !assignable_logic_input |=> state_ff != st_armed)
      else $error("run edge cleared with logic input assigned");
   a_flash_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == st_run ##1 state_ff == st_run |-> !ind_ff.display_flash)
      else $error("display flashing with no fault");
   a_auto_as_manual: assert property (@(posedge sys_clk) disable iff (!rstn)
      state_ff == st_run && auto_flt && !auto_restart_en |=> state_ff == st_manual)
      else $error("auto fault not handled as manual");
   a_history_shift: assert property (@(posedge sys_clk) disable iff (!rstn)
      log_evt |=> hist_ff[0] == $past(log_code) && hist_ff[1] == $past(hist_ff[0]))
      else $error("history not shifted");

endmodule : motor_starter_fault_supervisor

// ==== plc_operator_model.sv ====
`timescale 1ns/100ps

// Stand-in for the operator or PLC that drives the run and logic inputs
module plc_operator_model (
   input  wire logic sys_clk,
   output logic      run_cmd,
   output logic      assignable_logic_input
);
   // Idle at time zero: no run command, no clear pulse
   initial begin
      run_cmd = 1'b0;
      assignable_logic_input = 1'b0;
   end

   // clean run edge
   // Low for two cycles first so the rise is seen even from a held command
   task automatic run_rise();
      @(posedge sys_clk);
      run_cmd <= 1'b0;
      repeat (2) @(posedge sys_clk);
      run_cmd <= 1'b1;
   endtask : run_rise

   // run held high
   // Two-wire style: the command stays up until another edge is asked for
   task automatic run_hold();
      @(posedge sys_clk);
      run_cmd <= 1'b1;
   endtask : run_hold

   // Clear pulse on the logic input, two cycles wide
   task automatic pulse_clear();
      @(posedge sys_clk);
      assignable_logic_input <= 1'b1;
      repeat (2) @(posedge sys_clk);
      assignable_logic_input <= 1'b0;
   endtask : pulse_clear
endmodule : plc_operator_model

// ==== motor_starter_fault_supervisor_tb_top.sv ====
`timescale 1ns/100ps
`include "fault_supervisor_cfg.svh"
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module motor_starter_fault_supervisor_tb_top;
   import fault_supervisor_pkg::*;
   logic          sys_clk = 1'b0;
   logic          rstn = 1'b0;
   logic          run_cmd, assignable_logic_input;
   logic          fault_clear_input_function = 1'b0, auto_restart_en = 1'b1;
   logic          relay1_is_isolation = 1'b1, single_phase = 1'b0;
   current_meas_t meas = '0;
   logic          freq_out_of_band = 1'b0, control_supply_ok = 1'b1, power_supply_ok = 1'b1;
   logic          bypass_steady = 1'b1;
   logic [2:0]    man_src = 3'h0;
   logic [2:0]    hist_sel = 3'h0;
   indicate_t     ind;
   logic          drive_en;
   logic [3:0]    hist_code;
   logic [2:0]    attempts;
   logic          chk_req = 1'b0;
   logic [14:0]   notes[$];
   int            miscompares = 0;
   int            samples_checked = 0;
   wire  [14:0]   obs = {ind, drive_en, attempts, hist_code};

   // 200 MHz system clock
   always #2.5 sys_clk = ~sys_clk;

   plc_operator_model op (.sys_clk(sys_clk), .run_cmd(run_cmd), .assignable_logic_input(assignable_logic_input));

   // Short restart gap keeps the six-attempt escalation within a few hundred cycles
   motor_starter_fault_supervisor #(.RESTART_GAP_CYC(36'h32)) DUT (
      .sys_clk(sys_clk), .rstn(rstn), .run_cmd(run_cmd),
      .assignable_logic_input(assignable_logic_input),
      .fault_clear_input_function(fault_clear_input_function),
      .auto_restart_en(auto_restart_en), .relay1_is_isolation(relay1_is_isolation),
      .single_phase(single_phase), .meas(meas), .freq_out_of_band(freq_out_of_band),
      .control_supply_ok(control_supply_ok), .power_supply_ok(power_supply_ok),
      .bypass_steady(bypass_steady), .thermistor_hot(man_src[0]), .external_fault(man_src[1]),
      .motor_underload_fault(man_src[2]), .hist_sel(hist_sel), .ind_ff(ind),
      .motor_drive_en_ff(drive_en), .hist_code_ff(hist_code), .attempts_ff(attempts));

   function automatic logic [14:0] mk(input logic rs, input logic iso, input logic fl, input logic [3:0] cd,
                                      input logic dv, input logic [2:0] at, input logic [3:0] hc);
      return {rs, iso, fl, cd, dv, at, hc};
   endfunction : mk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wait_cyc

   // Let the two-cycle input-to-output path settle, then note the expected value
   task automatic chk(input logic [14:0] v);
      wait_cyc(3);
      notes.push_back(v);
      chk_req <= 1'b1;
      @(posedge sys_clk);
      chk_req <= 1'b0;
   endtask : chk

   // Fresh in-range currents per test, below the locked-rotor multiple and above threshold
   task automatic new_currents();
      @(posedge sys_clk);
      meas <= {16'h0064 + 16'($urandom % 32'h12d), 16'h0064 + 16'($urandom % 32'h12d),
               16'h0064 + 16'($urandom % 32'h12d), 16'h0064, 16'h000a};
   endtask : new_currents

   // Watcher samples at the falling edge, away from the edge that updates outputs
   always @(negedge sys_clk) begin
      if (chk_req === 1'b1 && notes.size() > 0) begin
         `CMP(obs, notes.pop_front())
      end
   end

   task automatic end_of_test();
      $display("Counts: %0d compared, %0d mismatched", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   // Whole sequence needs well under two thousand cycles
   initial begin
      wait_cyc(8000);
      miscompares++;
      end_of_test();
   end

   initial begin
      void'($urandom(74));
      // Reset spans 16 edges: 12 here and 4 inside the reset-value check
      wait_cyc(12);
      chk(15'h0000);
      rstn <= 1'b1;
      new_currents();
      op.run_hold();
      chk(mk(1, 1, 0, `FC_NONE, 1, 0, `FC_NONE));
      $display("test reset and start done");

      @(posedge sys_clk) freq_out_of_band <= 1'b1;
      chk(mk(0, 0, 1, `FC_LINE_FREQ, 0, 0, `FC_LINE_FREQ));
      @(posedge sys_clk) freq_out_of_band <= 1'b0;
      chk(mk(1, 1, 0, `FC_NONE, 1, 0, `FC_LINE_FREQ));
      $display("test auto fault isolation done");

      new_currents();
      @(posedge sys_clk) begin
         relay1_is_isolation <= 1'b0;
         freq_out_of_band <= 1'b1;
      end
      chk(mk(0, 1, 1, `FC_LINE_FREQ, 0, 0, `FC_LINE_FREQ));
      wait_cyc(120);
      chk(mk(0, 1, 1, `FC_LINE_FREQ, 0, 2, `FC_LINE_FREQ));
      wait_cyc(200);
      chk(mk(0, 0, 1, `FC_LINE_FREQ, 0, 6, `FC_ESCALATED));
      @(posedge sys_clk) hist_sel <= 3'h1;
      chk(mk(0, 0, 1, `FC_LINE_FREQ, 0, 6, `FC_LINE_FREQ));
      @(posedge sys_clk) hist_sel <= 3'h7;
      chk(mk(0, 0, 1, `FC_LINE_FREQ, 0, 6, `FC_NONE));
      @(posedge sys_clk) begin
         hist_sel <= 3'h0;
         freq_out_of_band <= 1'b0;
      end
      chk(mk(0, 0, 0, `FC_NONE, 0, 6, `FC_ESCALATED));
      op.run_rise();
      op.run_rise();
      chk(mk(1, 1, 0, `FC_NONE, 1, 0, `FC_ESCALATED));
      $display("test escalation done");

      @(posedge sys_clk) begin
         auto_restart_en <= 1'b0;
         fault_clear_input_function <= 1'b1;
         freq_out_of_band <= 1'b1;
      end
      chk(mk(0, 0, 1, `FC_LINE_FREQ, 0, 0, `FC_LINE_FREQ));
      @(posedge sys_clk) freq_out_of_band <= 1'b0;
      op.run_rise();
      op.run_rise();
      chk(mk(0, 0, 0, `FC_NONE, 0, 0, `FC_LINE_FREQ));
      op.pulse_clear();
      op.run_rise();
      chk(mk(1, 1, 0, `FC_NONE, 1, 0, `FC_LINE_FREQ));
      @(posedge sys_clk) begin
         auto_restart_en <= 1'b1;
         fault_clear_input_function <= 1'b0;
         relay1_is_isolation <= 1'b1;
      end
      $display("test no auto restart done");

      // Each manual-class source in turn: thermistor, external, underload
      for (int i = 0; i < 3; i++) begin
         new_currents();
         @(posedge sys_clk) man_src <= 3'(1 << i);
         chk(mk(0, 0, 1, 4'(`FC_THERMISTOR + i), 0, 0, 4'(`FC_THERMISTOR + i)));
         op.run_rise();
         chk(mk(0, 0, 1, 4'(`FC_THERMISTOR + i), 0, 0, 4'(`FC_THERMISTOR + i)));
         @(posedge sys_clk) man_src <= 3'h0;
         op.run_rise();
         op.run_rise();
         chk(mk(1, 1, 0, `FC_NONE, 1, 0, 4'(`FC_THERMISTOR + i)));
      end
      $display("test manual faults done");

      @(posedge sys_clk) power_supply_ok <= 1'b0;
      op.run_rise();
      chk(mk(0, 0, 1, `FC_SUPPLY, 0, 0, `FC_SUPPLY));
      @(posedge sys_clk) power_supply_ok <= 1'b1;
      chk(mk(1, 1, 0, `FC_NONE, 1, 0, `FC_SUPPLY));
      $display("test supply at run done");
      end_of_test();
   end
endmodule : motor_starter_fault_supervisor_tb_top
